// File: ussl_top.sv
// Synchronous slave serial port with AXI4-Lite register access.
// Assumes shift clock and data pin come from an external master.
//
// Contract
// - Shift clock comes from external master only
// - Clearing clock-source bit selects slave mode
// - Shifting continues while core sleeps
// - Slave transfers behave like master transfers
// - First written word loads shifter immediately
// - Empty flag clear while second word waits
// - After shift, reload second, then set empty
// - Enabled empty event wakes chip, vector 0004h
// - Single-receive enable ignored in slave mode
// - Continuous receive completes during sleep
// - Full word moves to holding; may wake
// - Receive flag set on completion, interrupt
// - Clearing continuous receive clears errors
// - Receive data sampled at falling clock edge
// - Two-entry queue; third word overruns
// - Overrun blocks transfers into queue
// - Receive flag clears when queue empty
module ussl_top
	import ussl_pkg::*;
#(
	parameter int DATA_BITS = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ussl_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ussl_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic shift_clock_pin,
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe,
	output logic core_wake,
	output logic [3:0] wake_vector
);
	import ussl_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] irq_en;
	logic [7:0] rx_ctl;
	logic [7:0] tx_ctl;
	logic [7:0] baud_divisor;
	logic core_sleep;
	logic global_ie;
	logic [7:0] tx_hold;
	logic tx_hold_9;
	logic tx_hold_full;
	logic [8:0] tx_shift;
	logic [3:0] tx_count;
	logic tx_busy;
	logic tx_empty_flag;
	ussl_word_t rx_fifo [2];
	logic [1:0] rx_level;
	logic rx_rd_ptr;
	logic rx_wr_ptr;
	logic [8:0] rx_shift;
	logic [3:0] rx_count;
	logic overrun_error_flag;
	logic [2:0] ck_sync;
	logic ck_state;

	// ****************************************
	// Bus slave
	// ****************************************
	logic [ADDR_W-1:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic w_held;
	logic do_write;
	logic do_read;
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic rd_rx_hold;
	logic wr_tx_hold;

	function automatic logic [7:0] to_index(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:2];
	endfunction

	function automatic logic known(input logic [7:0] i);
		return i == IDX_PIRQ_FLAGS || i == IDX_RX_STATCTL ||
			i == IDX_TX_HOLD || i == IDX_RX_HOLD ||
			i == IDX_PIRQ_ENABLES || i == IDX_TX_STATCTL ||
			i == IDX_BAUD_DIVISOR || i == IDX_SLEEP_CTL;
	endfunction

	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_idx = to_index(aw_addr);
	assign rd_idx = to_index(s_axi_araddr);
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign rd_rx_hold = do_read && rd_idx == IDX_RX_HOLD;
	assign wr_tx_hold = do_write && wr_idx == IDX_TX_HOLD;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_data <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= known(wr_idx) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !do_read;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= known(rd_idx) ? RESP_OKAY : RESP_SLVERR;
				unique case (rd_idx)
					IDX_PIRQ_FLAGS: s_axi_rdata <= {24'h0, 2'b00,
						rx_level != 2'd0, tx_empty_flag, 4'h0};
					IDX_RX_STATCTL: s_axi_rdata <= {24'h0, rx_ctl[7:3],
						1'b0, overrun_error_flag, rx_fifo[rx_rd_ptr].bits[8]};
					IDX_RX_HOLD: s_axi_rdata <= {24'h0,
						rx_fifo[rx_rd_ptr].bits[7:0]};
					IDX_PIRQ_ENABLES: s_axi_rdata <= {24'h0, irq_en};
					IDX_TX_STATCTL: s_axi_rdata <= {24'h0, tx_ctl[7:2],
						!tx_busy, tx_ctl[0]};
					IDX_BAUD_DIVISOR: s_axi_rdata <= {24'h0, baud_divisor};
					IDX_SLEEP_CTL: s_axi_rdata <= {30'h0, global_ie,
						core_sleep};
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en <= RST_ZERO;
			rx_ctl <= RST_ZERO;
			tx_ctl <= RST_TX_STATCTL;
			baud_divisor <= RST_ZERO;
			core_sleep <= 1'b0;
			global_ie <= 1'b0;
		end else begin
			if (core_wake)
				core_sleep <= 1'b0;
			if (do_write) begin
				unique case (wr_idx)
					IDX_PIRQ_ENABLES: irq_en <= w_data[7:0];
					IDX_RX_STATCTL: rx_ctl <= {w_data[7:3], 3'b000};
					IDX_TX_STATCTL: tx_ctl <= {w_data[7:2], 1'b0, w_data[0]};
					IDX_BAUD_DIVISOR: baud_divisor <= w_data[7:0];
					IDX_SLEEP_CTL: begin
						core_sleep <= w_data[0];
						global_ie <= w_data[1];
					end
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// Shift clock sampling
	// ****************************************
	logic slave_on;
	logic ck_fall;
	assign slave_on = rx_ctl[B_SERIAL_PORT_ENABLE] && tx_ctl[B_SYNC] && !tx_ctl[B_CLOCK_SOURCE_SELECT];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ck_sync <= 3'b000;
			ck_state <= 1'b0;
		end else begin
			ck_sync <= {ck_sync[1:0], shift_clock_pin};
			if (ck_sync[2] == ck_sync[1])
				ck_state <= ck_sync[2];
		end
	end
	assign ck_fall = slave_on && ck_sync[2] == ck_sync[1] && !ck_sync[2] && ck_state;

	// Data level counts once second and third stages agree
	logic [2:0] dt_sync;
	logic dt_state;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dt_sync <= 3'b000;
			dt_state <= 1'b0;
		end else begin
			dt_sync <= {dt_sync[1:0], serial_data_pin_in};
			if (dt_sync[2] == dt_sync[1])
				dt_state <= dt_sync[2];
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	logic tx_on;
	logic [3:0] tx_len;
	logic tx_done;
	assign tx_on = slave_on && tx_ctl[B_TRANSMIT_ENABLE_BIT];
	assign tx_len = tx_ctl[B_TX9] ? 4'(DATA_BITS + 1) : 4'(DATA_BITS);
	assign tx_done = tx_busy && ck_fall && tx_count == tx_len - 4'd1;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_hold <= RST_ZERO;
			tx_hold_9 <= 1'b0;
			tx_hold_full <= 1'b0;
			tx_shift <= '0;
			tx_count <= '0;
			tx_busy <= 1'b0;
			tx_empty_flag <= 1'b0;
			serial_data_pin_out <= 1'b0;
			serial_data_pin_oe <= 1'b0;
		end else begin
			serial_data_pin_oe <= tx_on && tx_busy;
			if (wr_tx_hold) begin
				tx_hold <= w_data[7:0];
				tx_hold_9 <= tx_ctl[B_TRANSMIT_NINTH_BIT];
				tx_hold_full <= 1'b1;
				tx_empty_flag <= 1'b0;
			end
			if (!tx_on) begin
				// Flag keeps its value while transmit is off, except that a TX_HOLD write clears it
				tx_busy <= 1'b0;
				tx_count <= '0;
			end else if ((!tx_busy || tx_done) && tx_hold_full) begin
				tx_shift <= {tx_hold_9, tx_hold};
				serial_data_pin_out <= tx_hold[0];
				tx_busy <= 1'b1;
				tx_count <= '0;
				tx_hold_full <= wr_tx_hold;
				tx_empty_flag <= !wr_tx_hold;
			end else if (tx_done) begin
				tx_busy <= 1'b0;
			end else if (tx_busy && ck_fall) begin
				tx_shift <= {1'b0, tx_shift[8:1]};
				serial_data_pin_out <= tx_shift[1];
				tx_count <= tx_count + 4'd1;
			end
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	logic rx_on;
	logic [3:0] rx_len;
	logic rx_last;
	logic [8:0] rx_word;
	assign rx_on = slave_on && rx_ctl[B_CONTINUOUS_RECEIVE_ENABLE];
	assign rx_len = rx_ctl[B_RX9] ? 4'(DATA_BITS + 1) : 4'(DATA_BITS);
	assign rx_last = rx_on && ck_fall && rx_count == rx_len - 4'd1;
	assign rx_word = rx_ctl[B_RX9] ? {dt_state, rx_shift[8:1]} :
		{1'b0, dt_state, rx_shift[8:2]};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_shift <= '0;
			rx_count <= '0;
			rx_level <= 2'd0;
			rx_rd_ptr <= 1'b0;
			rx_wr_ptr <= 1'b0;
			overrun_error_flag <= 1'b0;
			rx_fifo[0] <= '0;
			rx_fifo[1] <= '0;
		end else begin
			if (!rx_on) begin
				rx_count <= '0;
				overrun_error_flag <= 1'b0;
			end else if (ck_fall) begin
				rx_shift <= {dt_state, rx_shift[8:1]};
				rx_count <= rx_last ? 4'd0 : rx_count + 4'd1;
			end
			if (rx_last && rx_level == 2'd2 && !rd_rx_hold)
				overrun_error_flag <= 1'b1;
			if (rx_last && !overrun_error_flag &&
				(rx_level != 2'd2 || rd_rx_hold)) begin
				rx_fifo[rx_wr_ptr].bits <= rx_word;
				rx_wr_ptr <= !rx_wr_ptr;
			end
			if (rd_rx_hold && rx_level != 2'd0)
				rx_rd_ptr <= !rx_rd_ptr;
			rx_level <= rx_level
				+ ((rx_last && !overrun_error_flag &&
					(rx_level != 2'd2 || rd_rx_hold)) ? 2'd1 : 2'd0)
				- ((rd_rx_hold && rx_level != 2'd0) ? 2'd1 : 2'd0);
		end
	end

	// ****************************************
	// Wake-up
	// ****************************************
	logic wake_req;
	assign wake_req = (tx_empty_flag && irq_en[B_TX_EMPTY]) ||
		(rx_level != 2'd0 && irq_en[B_RX_AVAIL]);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_wake <= 1'b0;
			wake_vector <= 4'h0;
		end else begin
			core_wake <= core_sleep && wake_req;
			wake_vector <= (wake_req && global_ie) ? WAKE_VECTOR : 4'h0;
		end
	end
endmodule

// File: ussl_pkg.sv
// Package for the synchronous slave serial port: map, fields, types.
// Assumes AXI4-Lite with 32-bit data; register data in bits 7:0.
package ussl_pkg;
	// ****************************************
	// Register indexes (byte address is index times 4)
	// ****************************************
	localparam logic [7:0] IDX_PIRQ_FLAGS = 8'h0c;
	localparam logic [7:0] IDX_RX_STATCTL = 8'h18;
	localparam logic [7:0] IDX_TX_HOLD = 8'h19;
	localparam logic [7:0] IDX_RX_HOLD = 8'h1a;
	localparam logic [7:0] IDX_PIRQ_ENABLES = 8'h8c;
	localparam logic [7:0] IDX_TX_STATCTL = 8'h98;
	localparam logic [7:0] IDX_BAUD_DIVISOR = 8'h99;
	localparam logic [7:0] IDX_SLEEP_CTL = 8'hc0;
	localparam int ADDR_W = 10;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int B_RX_AVAIL = 5;
	localparam int B_TX_EMPTY = 4;
	localparam int B_SERIAL_PORT_ENABLE = 7;
	localparam int B_RX9 = 6;
	localparam int B_SINGLE_RECEIVE_ENABLE = 5;
	localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
	localparam int B_FRAMING_ERROR_FLAG = 2;
	localparam int B_OVERRUN_ERROR_FLAG = 1;
	localparam int B_RECEIVED_NINTH_BIT = 0;
	localparam int B_CLOCK_SOURCE_SELECT = 7;
	localparam int B_TX9 = 6;
	localparam int B_TRANSMIT_ENABLE_BIT = 5;
	localparam int B_SYNC = 4;
	localparam int B_SHIFT_REGISTER_EMPTY_STATUS = 1;
	localparam int B_TRANSMIT_NINTH_BIT = 0;
	// ****************************************
	// Reset values, response codes and wake vector
	// ****************************************
	localparam logic [7:0] RST_TX_STATCTL = 8'h02;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [3:0] WAKE_VECTOR = 4'h4;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} ussl_wr_t;

	typedef struct packed {
		logic [8:0] bits;
	} ussl_word_t;
endpackage

// File: ussl_props.sv
// Checker for the slave serial port, bound to the top module.
// Assumes the AXI4-Lite and pin ports of ussl_top.
module ussl_props
	import ussl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic shift_clock_pin,
	input wire logic serial_data_pin_out,
	input wire logic serial_data_pin_oe,
	input wire logic [3:0] wake_vector
);
	logic [3:0] fall_age;
	logic [3:0] write_age;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Cycles since clock fall and since write data taken
	always_ff @(posedge aclk) begin
		if (!aresetn || $fell(shift_clock_pin))
			fall_age <= 4'hf;
		if (!aresetn || (s_axi_wvalid && s_axi_wready))
			write_age <= 4'hf;
		if ($fell(shift_clock_pin))
			fall_age <= 4'h0;
		else if (aresetn && fall_age != 4'hf)
			fall_age <= fall_age + 4'h1;
		if (s_axi_wvalid && s_axi_wready)
			write_age <= 4'h0;
		else if (aresetn && write_age != 4'hf)
			write_age <= write_age + 4'h1;
	end
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_aw_once: assert property (s_axi_awvalid && s_axi_awready
		|=> !s_axi_awready) else $error("address taken twice");
	a_err_zero: assert property (s_axi_rvalid
		&& s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read with data");
	a_ready_up: assert property ($rose(aresetn)
		|-> ##1 s_axi_awready && s_axi_arready)
		else $error("ready late after reset");
	a_vec_value: assert property (
		wake_vector != 4'h0 |-> wake_vector == WAKE_VECTOR)
		else $error("bad wake vector");
	a_tx_on_fall: assert property (
		serial_data_pin_oe && $past(serial_data_pin_oe)
		&& $changed(serial_data_pin_out)
		|-> fall_age < 4'h8 || write_age < 4'h8)
		else $error("data pin moved without clock fall");
endmodule

bind ussl_top ussl_props ussl_props_inst (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.shift_clock_pin, .serial_data_pin_out, .serial_data_pin_oe,
	.wake_vector);

// File: ussl_master_model.sv
// External master: makes the shift clock, drives and reads data.
// Assumes the bench resolves the two-way data pin into pin_level.
module ussl_master_model (
	output logic shift_clk,
	output logic data_drive,
	input wire logic pin_level
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		shift_clk = 1'b0;
		data_drive = 1'b0;
	end
	// One word LSB first; clock still between frames
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 0; i < 8; i++) begin
			#62.5 shift_clk = 1'b1;
			data_drive = tx[i];
			rx[i] = pin_level;
			#62.5 shift_clk = 1'b0;
		end
		#62.5 data_drive = ~data_drive;
	endtask
endmodule

// File: tb_top.sv
// Bench for the slave serial port: registers, transmit, receive.
// Assumes ussl_pkg, ussl_top and the master model.
module tb_top;
	import ussl_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [9:0] A_FLG = {IDX_PIRQ_FLAGS, 2'b00};
	localparam logic [9:0] A_RXS = {IDX_RX_STATCTL, 2'b00};
	localparam logic [9:0] A_TXH = {IDX_TX_HOLD, 2'b00};
	localparam logic [9:0] A_RXH = {IDX_RX_HOLD, 2'b00};
	localparam logic [9:0] A_PIE = {IDX_PIRQ_ENABLES, 2'b00};
	localparam logic [9:0] A_TXS = {IDX_TX_STATCTL, 2'b00};
	localparam logic [9:0] A_BAUD = {IDX_BAUD_DIVISOR, 2'b00};
	localparam logic [9:0] A_SLP = {IDX_SLEEP_CTL, 2'b00};
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, shift_clock_pin, data_drive, pin_level;
	logic serial_data_pin_out, serial_data_pin_oe, core_wake;
	logic [3:0] wake_vector;
	logic [7:0] w0, w1, got;
	logic [7:0] q [4];
	int num_errors = 0, n_tests = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	int n_wakes = 0, wk = 0;
	// Cycles in which the core is being woken
	always @(posedge aclk) begin
		if (core_wake === 1'b1)
			n_wakes++;
	end
	assign pin_level = serial_data_pin_oe ? serial_data_pin_out : data_drive;
	always #5 aclk = ~aclk;
	ussl_top ussl_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shift_clock_pin,
		.serial_data_pin_in(pin_level), .serial_data_pin_out,
		.serial_data_pin_oe, .core_wake, .wake_vector);
	ussl_master_model ussl_master_model_inst (.shift_clk(shift_clock_pin),
		.data_drive, .pin_level);
	// ****************************************
	// Tasks
	// ****************************************
	function automatic logic over(input int n);
		return n > 2;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h0, v};
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rchk(input logic [9:0] a, input logic [7:0] e);
		rd(a);
		chk(d, {24'h0, e});
	endtask
	task automatic rbit(input logic [9:0] a, input int b, input logic e);
		rd(a);
		chk({31'h0, d[b]}, {31'h0, e});
	endtask
	task automatic frame(input logic [7:0] t);
		ussl_master_model_inst.xfer(t, got);
		repeat (10) @(posedge aclk);
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#300000;
		num_errors++;
		report_and_stop;
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		void'($urandom(36178));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(A_FLG, RST_ZERO);
		rchk(A_RXS, RST_ZERO);
		rchk(A_RXH, RST_ZERO);
		rchk(A_PIE, RST_ZERO);
		rchk(A_TXS, RST_TX_STATCTL);
		rchk(A_BAUD, RST_ZERO);
		rd(10'h004);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		w0 = 8'($urandom);
		wr(A_BAUD, w0);
		rchk(A_BAUD, w0);
		s_axi_wstrb <= 4'h0;
		wr(A_BAUD, ~w0);
		s_axi_wstrb <= 4'hf;
		rchk(A_BAUD, 8'h00);
		$display("test registers done");
		wr(A_RXS, 8'h80);
		wr(A_PIE, 8'h10);
		wr(A_TXS, 8'h30);
		w0 = 8'($urandom);
		w1 = 8'($urandom);
		wr(A_TXH, w0);
		wr(A_TXH, w1);
		wr(A_SLP, 8'h03);
		rchk(A_SLP, 8'h03);
		chk(32'(n_wakes), 32'h0);
		rbit(A_FLG, B_TX_EMPTY, 1'b0);
		frame(8'h00);
		chk({24'h0, got}, {24'h0, w0});
		rbit(A_FLG, B_TX_EMPTY, 1'b1);
		chk({31'h0, n_wakes > 0}, 32'h1);
		chk({28'h0, wake_vector}, {28'h0, WAKE_VECTOR});
		rchk(A_SLP, 8'h02);
		frame(8'h00);
		chk({24'h0, got}, {24'h0, w1});
		$display("test transmit done");
		wr(A_TXS, 8'h10);
		wr(A_PIE, 8'h20);
		wr(A_RXS, 8'ha0);
		frame(w0);
		rbit(A_FLG, B_RX_AVAIL, 1'b0);
		wr(A_RXS, 8'h90);
		wr(A_SLP, 8'h03);
		wk = n_wakes;
		frame(w1);
		chk({31'h0, n_wakes > wk}, 32'h1);
		rbit(A_FLG, B_RX_AVAIL, 1'b1);
		rchk(A_SLP, 8'h02);
		rchk(A_RXH, w1);
		rbit(A_FLG, B_RX_AVAIL, 1'b0);
		$display("test receive done");
		for (int k = 0; k < 4; k++) begin
			q[k] = 8'($urandom);
			frame(q[k]);
		end
		rbit(A_RXS, B_OVERRUN_ERROR_FLAG, over(3));
		rchk(A_RXH, q[0]);
		rchk(A_RXH, q[1]);
		rbit(A_FLG, B_RX_AVAIL, 1'b0);
		wr(A_RXS, 8'h80);
		rbit(A_RXS, B_OVERRUN_ERROR_FLAG, 1'b0);
		$display("test overrun done");
		report_and_stop;
	end
endmodule
